//--- hw/emi_pkg.sv
// Purpose: shared constants for the external data memory interface
// Assumes: 8-bit special-function-register port, one system clock
// Notes:   offsets, fields, reset values and timing counts live here only
package emi_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register offsets on the special-function-register port
	localparam logic [7:0] PAGE_OFS = 8'h00_aa;
	localparam logic [7:0] CFG_OFS  = 8'h00_ab;
	localparam logic [7:0] DPL_OFS  = 8'h00_82;
	localparam logic [7:0] DPH_OFS  = 8'h00_83;

	// reset values
	localparam logic [7:0] PAGE_RST = 8'h00_00;
	localparam logic [4:0] CFG_RST  = 5'h0_03;
	localparam logic [7:0] DP_RST   = 8'h00_00;

	// configuration fields
	localparam int CFG_BUS_STYLE_BIT = 4;
	localparam int CFG_MODE_LSB      = 2;
	localparam int CFG_ALE_LSB       = 0;
	localparam int CFG_WIDTH         = 5;

	// memory-mode field encodings
	localparam logic [1:0] MODE_INTERNAL  = 2'h0;
	localparam logic [1:0] MODE_SPLIT_NB  = 2'h1;
	localparam logic [1:0] MODE_SPLIT_BS  = 2'h2;
	localparam logic [1:0] MODE_EXTERNAL  = 2'h3;

	// on-chip space: 8 kB, so 13 address bits
	localparam int RAM_AW = 13;

	// pin positions of the strobes on port 3
	localparam int PIN_ALE = 5;
	localparam int PIN_RD  = 6;
	localparam int PIN_WR  = 7;

	// timing counts in system clock cycles
	localparam logic [2:0] SETUP_CYC  = 3'h1;
	localparam logic [2:0] STROBE_CYC = 3'h1;
	localparam logic [2:0] HOLD_CYC   = 3'h1;

	// sequencer states, one-hot
	typedef enum logic [7:0] {
		ST_IDLE   = 8'b0000_0001,
		ST_RAM    = 8'b0000_0010,
		ST_SETUP  = 8'b0000_0100,
		ST_ALE_HI = 8'b0000_1000,
		ST_ALE_LO = 8'b0001_0000,
		ST_STROBE = 8'b0010_0000,
		ST_HOLD   = 8'b0100_0000,
		ST_DONE   = 8'b1000_0000
	} emi_state_e;

endpackage

//--- hw/emi_addr_gen.sv
// Purpose: effective address and on-chip or off-chip routing of one move
// Assumes: purely combinational, sampled by the sequencer at request time
// Notes:   wrap into on-chip space simply drops the upper address bits
module emi_addr_gen (
	// access description
	input  wire logic [1:0]               mode,
	input  wire logic                     wide,
	input  wire logic [7:0]               page,
	input  wire logic [15:0]              data_pointer,
	input  wire logic [7:0]               index,
	// results
	output logic      [15:0]              eff_addr,
	output logic                          on_chip,
	output logic                          drive_high,
	output logic      [emi_pkg::RAM_AW-1:0] ram_addr
);
	logic below_boundary;

	// 16-bit form uses the pointer, 8-bit form joins page and index
	assign eff_addr = wide ? data_pointer : {page, index};
	assign below_boundary = (eff_addr[15:emi_pkg::RAM_AW] == '0);
	// mode 00 always on-chip, 11 never, split modes cut at 8 kB
	assign on_chip = (mode == emi_pkg::MODE_INTERNAL) ||
		(((mode == emi_pkg::MODE_SPLIT_NB) || (mode == emi_pkg::MODE_SPLIT_BS))
			&& below_boundary);
	// upper byte left to the port latches for 8-bit moves except bank select
	assign drive_high = wide || (mode == emi_pkg::MODE_SPLIT_BS);
	assign ram_addr = eff_addr[emi_pkg::RAM_AW-1:0];
endmodule

//--- hw/emi_phase_timer.sv
// Purpose: down counter that times each phase of an off-chip move
// Assumes: load value of at least one cycle
// Notes:   expired is high in the last cycle of the phase
module emi_phase_timer #(
	parameter int W = 3
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         arst_n,
	// control
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	// status
	output logic              expired
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;

	// load holds cycles minus one, so a one-cycle phase expires at once
	assign cnt_d = load ? W'(load_val - W'(1)) : ((cnt_q != '0) ? W'(cnt_q - W'(1)) : cnt_q);
	assign expired = (cnt_q == '0);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule

//--- hw/emi_ctrl.sv
// Purpose: external data space controller: registers, routing, pin sequencing
// Assumes: core issues one move at a time and waits for mx_done
// Notes:   on-chip RAM sits outside, read data valid one cycle after ram_en
module emi_ctrl (
	// clock and reset
	input  wire logic                       clk,
	input  wire logic                       arst_n,
	// special-function-register port
	input  wire logic [7:0]                 sfr_addr,
	input  wire logic                       sfr_wr,
	input  wire logic [7:0]                 sfr_wdata,
	output logic      [7:0]                 sfr_rdata,
	// move request from the core
	input  wire logic                       mx_req,
	input  wire logic                       mx_wide,
	input  wire logic                       mx_write,
	input  wire logic [7:0]                 mx_index,
	input  wire logic [7:0]                 mx_wdata,
	output logic                            mx_done,
	output logic      [7:0]                 mx_rdata,
	// on-chip RAM
	output logic                            ram_en,
	output logic                            ram_we,
	output logic      [emi_pkg::RAM_AW-1:0] ram_addr,
	output logic      [7:0]                 ram_wdata,
	input  wire logic [7:0]                 ram_rdata,
	// port latch values and pad inputs
	input  wire logic [7:0]                 p3_latch,
	input  wire logic [7:0]                 p4_latch,
	input  wire logic [7:0]                 p5_latch,
	input  wire logic [7:0]                 p6_latch,
	input  wire logic [7:0]                 p6_in,
	// pin drive: value, low-active enable, and claim mask
	output logic      [7:0]                 p3_out,
	output logic      [7:0]                 p3_oe_n,
	output logic      [7:0]                 p3_own,
	output logic      [7:0]                 p4_out,
	output logic      [7:0]                 p4_oe_n,
	output logic      [7:0]                 p4_own,
	output logic      [7:0]                 p5_out,
	output logic      [7:0]                 p5_oe_n,
	output logic      [7:0]                 p5_own,
	output logic      [7:0]                 p6_out,
	output logic      [7:0]                 p6_oe_n,
	output logic      [7:0]                 p6_own
);

	////////////////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0]                    page_q;
	logic [emi_pkg::CFG_WIDTH-1:0] cfg_q;
	logic [7:0]                    dpl_q;
	logic [7:0]                    dph_q;
	logic [7:0]                    sfr_rdata_q;

	// decode of the register port
	wire wr_page = sfr_wr && (sfr_addr == emi_pkg::PAGE_OFS);
	wire wr_cfg  = sfr_wr && (sfr_addr == emi_pkg::CFG_OFS);
	wire wr_dpl  = sfr_wr && (sfr_addr == emi_pkg::DPL_OFS);
	wire wr_dph  = sfr_wr && (sfr_addr == emi_pkg::DPH_OFS);

	wire [1:0] cfg_mode = cfg_q[emi_pkg::CFG_MODE_LSB +: 2];
	wire [1:0] cfg_ale  = cfg_q[emi_pkg::CFG_ALE_LSB +: 2];
	wire       cfg_sep  = cfg_q[emi_pkg::CFG_BUS_STYLE_BIT];

	// read mux; unmapped offsets read zero, upper config bits always zero
	logic [7:0] sfr_rdata_d;
	assign sfr_rdata_d =
		(sfr_addr == emi_pkg::PAGE_OFS) ? page_q :
		(sfr_addr == emi_pkg::CFG_OFS)  ? {3'h0, cfg_q} :
		(sfr_addr == emi_pkg::DPL_OFS)  ? dpl_q :
		(sfr_addr == emi_pkg::DPH_OFS)  ? dph_q : 8'h00_00;

	// register writes; bits 7:5 of a config write are dropped
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			page_q      <= emi_pkg::PAGE_RST;
			cfg_q       <= emi_pkg::CFG_RST;
			dpl_q       <= emi_pkg::DP_RST;
			dph_q       <= emi_pkg::DP_RST;
			sfr_rdata_q <= 8'h00_00;
		end else begin
			if (wr_page) page_q <= sfr_wdata;
			if (wr_cfg) cfg_q <= sfr_wdata[emi_pkg::CFG_WIDTH-1:0];
			if (wr_dpl) dpl_q <= sfr_wdata;
			if (wr_dph) dph_q <= sfr_wdata;
			sfr_rdata_q <= sfr_rdata_d;
		end
	end
	assign sfr_rdata = sfr_rdata_q;

	////////////////////////////////////////////////////////////////////////////////
	// address generation
	logic [15:0]                eff_addr;
	logic                       on_chip;
	logic                       drive_high;
	logic [emi_pkg::RAM_AW-1:0] ram_addr_w;

	emi_addr_gen u_addr (
		.mode       (cfg_mode),
		.wide       (mx_wide),
		.page       (page_q),
		.data_pointer       ({dph_q, dpl_q}),
		.index      (mx_index),
		.eff_addr   (eff_addr),
		.on_chip    (on_chip),
		.drive_high (drive_high),
		.ram_addr   (ram_addr_w)
	);

	////////////////////////////////////////////////////////////////////////////////
	// per-move capture; config is frozen so a mid-move write cannot tear it
	emi_pkg::emi_state_e state_q;
	emi_pkg::emi_state_e state_d;
	logic [15:0] addr_q;
	logic        write_q;
	logic        sep_q;
	logic        hi_q;
	logic [1:0]  ale_q;
	logic [7:0]  wdata_q;
	logic [7:0]  rbuf_q;
	logic        from_ram_q;

	wire start = (state_q == emi_pkg::ST_IDLE) && mx_req;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			addr_q     <= 16'h0000;
			write_q    <= 1'b0;
			sep_q      <= 1'b0;
			hi_q       <= 1'b0;
			ale_q      <= 2'h0;
			wdata_q    <= 8'h00_00;
			from_ram_q <= 1'b0;
		end else if (start) begin
			addr_q     <= eff_addr;
			write_q    <= mx_write;
			sep_q      <= cfg_sep;
			hi_q       <= drive_high;
			ale_q      <= cfg_ale;
			wdata_q    <= mx_wdata;
			from_ram_q <= on_chip;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// phase timer
	logic       tmr_load;
	logic [2:0] tmr_val;
	logic       tmr_exp;
	wire  [2:0] ale_cyc = {1'b0, ale_q} + 3'h1;

	emi_phase_timer #(.W(3)) u_tmr (
		.clk      (clk),
		.arst_n   (arst_n),
		.load     (tmr_load),
		.load_val (tmr_val),
		.expired  (tmr_exp)
	);

	// sequencer: mux goes ale high, ale low, strobe; separate goes setup, strobe
	always_comb begin
		state_d  = state_q;
		tmr_load = 1'b0;
		tmr_val  = emi_pkg::SETUP_CYC;
		case (state_q)
			emi_pkg::ST_IDLE: begin
				if (mx_req && on_chip) begin
					state_d = emi_pkg::ST_RAM;
				end else if (mx_req && cfg_sep) begin
					state_d  = emi_pkg::ST_SETUP;
					tmr_load = 1'b1;
				end else if (mx_req) begin
					state_d  = emi_pkg::ST_ALE_HI;
					tmr_load = 1'b1;
					tmr_val  = {1'b0, cfg_ale} + 3'h1;
				end
			end
			emi_pkg::ST_RAM: state_d = emi_pkg::ST_DONE;
			emi_pkg::ST_SETUP: begin
				if (tmr_exp) begin
					state_d  = emi_pkg::ST_STROBE;
					tmr_load = 1'b1;
					tmr_val  = emi_pkg::STROBE_CYC;
				end
			end
			emi_pkg::ST_ALE_HI: begin
				if (tmr_exp) begin
					state_d  = emi_pkg::ST_ALE_LO;
					tmr_load = 1'b1;
					tmr_val  = ale_cyc;
				end
			end
			emi_pkg::ST_ALE_LO: begin
				if (tmr_exp) begin
					state_d  = emi_pkg::ST_STROBE;
					tmr_load = 1'b1;
					tmr_val  = emi_pkg::STROBE_CYC;
				end
			end
			emi_pkg::ST_STROBE: begin
				if (tmr_exp) begin
					state_d  = emi_pkg::ST_HOLD;
					tmr_load = 1'b1;
					tmr_val  = emi_pkg::HOLD_CYC;
				end
			end
			emi_pkg::ST_HOLD: if (tmr_exp) state_d = emi_pkg::ST_DONE;
			default: state_d = emi_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= emi_pkg::ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read data: pads sampled on the last strobe cycle, RAM in the done cycle
	logic [7:0] rdata_q;
	logic       done_q;
	wire        in_done = (state_q == emi_pkg::ST_DONE);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rbuf_q  <= 8'h00_00;
			rdata_q <= 8'h00_00;
			done_q  <= 1'b0;
		end else begin
			if ((state_q == emi_pkg::ST_STROBE) && tmr_exp) rbuf_q <= p6_in;
			if (in_done && !write_q) rdata_q <= from_ram_q ? ram_rdata : rbuf_q;
			done_q <= in_done;
		end
	end
	assign mx_done  = done_q;
	assign mx_rdata = rdata_q;

	// on-chip RAM strobes, registered from the next state
	logic                       ram_en_q;
	logic                       ram_we_q;
	logic [emi_pkg::RAM_AW-1:0] ram_addr_q;
	logic [7:0]                 ram_wdata_q;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ram_en_q    <= 1'b0;
			ram_we_q    <= 1'b0;
			ram_addr_q  <= '0;
			ram_wdata_q <= 8'h00_00;
		end else begin
			ram_en_q    <= start && on_chip;
			ram_we_q    <= start && on_chip && mx_write;
			if (start) ram_addr_q <= ram_addr_w;
			if (start) ram_wdata_q <= mx_wdata;
		end
	end
	assign ram_en    = ram_en_q;
	assign ram_we    = ram_we_q;
	assign ram_addr  = ram_addr_q;
	assign ram_wdata = ram_wdata_q;

	////////////////////////////////////////////////////////////////////////////////
	// pin drive computed from the next state; the output mode stays with the ports
	wire nx_ext    = !(state_d inside {emi_pkg::ST_IDLE, emi_pkg::ST_RAM,
		emi_pkg::ST_DONE});
	wire nx_ale    = (state_d == emi_pkg::ST_ALE_HI);
	wire nx_adr    = (state_d == emi_pkg::ST_ALE_HI) || (state_d == emi_pkg::ST_ALE_LO);
	wire nx_stb    = (state_d == emi_pkg::ST_STROBE);
	wire [15:0] ad = start ? eff_addr : addr_q;
	wire sep       = start ? cfg_sep : sep_q;
	wire hi        = start ? drive_high : hi_q;
	wire wr        = start ? mx_write : write_q;
	wire [7:0] wd  = start ? mx_wdata : wdata_q;

	// port 3: strobes, ale only in mux mode
	wire [7:0] p3_own_d = nx_ext ? {2'b11, !sep, 5'h00} : 8'h00;
	wire [7:0] p3_val_d = {!(nx_stb && wr), !(nx_stb && !wr), nx_ale, 5'h00};
	// port 6: low address in mux address phase, else data; read floats
	wire       p6_adr   = !sep && nx_adr;
	wire [7:0] p6_own_d = nx_ext ? 8'hff : 8'h00;
	wire [7:0] p6_val_d = p6_adr ? ad[7:0] : wd;
	wire       p6_drv   = p6_adr || wr;
	// port 5: high address in mux, low address when separate
	wire [7:0] p5_own_d = (nx_ext && (sep || hi)) ? 8'hff : 8'h00;
	wire [7:0] p5_val_d = sep ? ad[7:0] : ad[15:8];
	// port 4: high address only when separate
	wire [7:0] p4_own_d = (nx_ext && sep && hi) ? 8'hff : 8'h00;

	// unclaimed pins echo the latch with the driver off so ports take over
	logic [7:0] p3_out_q, p4_out_q, p5_out_q, p6_out_q;
	logic [7:0] p3_oe_q, p4_oe_q, p5_oe_q, p6_oe_q;
	logic [7:0] p3_own_q, p4_own_q, p5_own_q, p6_own_q;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			{p3_out_q, p4_out_q, p5_out_q, p6_out_q} <= 32'hffff_ffff;
			{p3_oe_q, p4_oe_q, p5_oe_q, p6_oe_q}     <= 32'hffff_ffff;
			{p3_own_q, p4_own_q, p5_own_q, p6_own_q} <= 32'h0000_0000;
		end else begin
			p3_out_q <= (p3_own_d & p3_val_d) | (~p3_own_d & p3_latch);
			p4_out_q <= (p4_own_d & ad[15:8]) | (~p4_own_d & p4_latch);
			p5_out_q <= (p5_own_d & p5_val_d) | (~p5_own_d & p5_latch);
			p6_out_q <= (p6_own_d & p6_val_d) | (~p6_own_d & p6_latch);
			p3_oe_q  <= ~p3_own_d;
			p4_oe_q  <= ~p4_own_d;
			p5_oe_q  <= ~p5_own_d;
			p6_oe_q  <= ~(p6_own_d & {8{p6_drv}});
			p3_own_q <= p3_own_d;
			p4_own_q <= p4_own_d;
			p5_own_q <= p5_own_d;
			p6_own_q <= p6_own_d;
		end
	end
	assign p3_out = p3_out_q;
	assign p4_out = p4_out_q;
	assign p5_out = p5_out_q;
	assign p6_out = p6_out_q;
	assign p3_oe_n = p3_oe_q;
	assign p4_oe_n = p4_oe_q;
	assign p5_oe_n = p5_oe_q;
	assign p6_oe_n = p6_oe_q;
	assign p3_own = p3_own_q;
	assign p4_own = p4_own_q;
	assign p5_own = p5_own_q;
	assign p6_own = p6_own_q;

	////////////////////////////////////////////////////////////////////////////////
	// checks; open-drain choice has no signal here to watch
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	logic [2:0] ale_run;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) ale_run <= 3'h0;
		else ale_run <= p3_out_q[emi_pkg::PIN_ALE] && p3_own_q[emi_pkg::PIN_ALE] ?
			3'(ale_run + 3'h1) : 3'h0;
	end

	a_cfg_upper_zero: assert property (
		(sfr_addr == emi_pkg::CFG_OFS) |=> (sfr_rdata[7:5] == 3'h0))
		else $error("config upper bits not zero");
	a_page_eff_addr: assert property (
		start && !mx_wide |=> (addr_q == {$past(page_q), $past(mx_index)}))
		else $error("8-bit move address not page and index");
	a_data_pointer_eff_addr: assert property (
		start && mx_wide |=> (addr_q == {$past(dph_q), $past(dpl_q)}))
		else $error("16-bit move address not the data pointer");
	a_internal_ram: assert property (
		start && (cfg_mode == emi_pkg::MODE_INTERNAL) |=> ram_en && (p6_own == 8'h00))
		else $error("internal mode move left the chip");
	a_wrap_ram_addr: assert property (
		start && on_chip |=> (ram_addr == $past(eff_addr[emi_pkg::RAM_AW-1:0])))
		else $error("on-chip address not wrapped");
	a_external_only: assert property (
		start && (cfg_mode == emi_pkg::MODE_EXTERNAL) |=> !ram_en ##1 (p3_own != 8'h00))
		else $error("external mode touched on-chip RAM");
	a_split_nobank_hi: assert property (
		start && !mx_wide && !on_chip && (cfg_mode == emi_pkg::MODE_SPLIT_NB)
		&& !cfg_sep |=> ##1 (p5_own == 8'h00))
		else $error("no-bank 8-bit move drove the high byte");
	a_bank_hi_page: assert property (
		start && !mx_wide && !on_chip && (cfg_mode == emi_pkg::MODE_SPLIT_BS)
		&& !cfg_sep |=> ##1 (p5_out == $past(page_q, 2)) && (p5_own == 8'hff))
		else $error("bank select high byte not the page");
	a_read_float: assert property (
		(state_q == emi_pkg::ST_STROBE) && !write_q |-> (p6_oe_n == 8'hff))
		else $error("data pins driven during a read");
	a_pins_released: assert property (
		(state_q inside {emi_pkg::ST_IDLE, emi_pkg::ST_DONE}) |->
		({p3_own, p4_own, p5_own, p6_own} == 32'h0000_0000))
		else $error("pins held outside an off-chip move");
	a_ale_width: assert property (
		(ale_run != 3'h0) |-> (ale_run <= {1'b0, ale_q} + 3'h1))
		else $error("latch strobe high too long");
	a_mux_phases: assert property (
		$fell(p3_out[emi_pkg::PIN_ALE]) && p3_own[emi_pkg::PIN_ALE] |->
		!p3_out[emi_pkg::PIN_RD] || !p3_out[emi_pkg::PIN_WR] || !$past(p6_oe_n[0]))
		else $error("shared pins not carrying address before strobe");
	a_sep_pinout: assert property (
		(state_q == emi_pkg::ST_STROBE) && sep_q |->
		(p5_out == addr_q[7:0]) && !p3_own[emi_pkg::PIN_ALE])
		else $error("separate bus pinout wrong");

	c_ram_move: cover property (start && on_chip ##2 mx_done);
	c_mux_read: cover property (start && !on_chip && !cfg_sep && !mx_write);
	c_sep_write: cover property (start && !on_chip && cfg_sep && mx_write);
	c_ale_long: cover property (ale_run == 3'h4);

endmodule

//--- test/emi_sram_model.sv
// Purpose: off-chip parallel memory hung on ports 3 to 6
// Assumes: read and write strobes low active, latch strobe high active
// Notes:   a released data line shows the inverse of its last value
module emi_sram_model (
	// clock and bus style
	input  wire logic       clk,
	input  wire logic       sep,
	// pins seen from the board
	input  wire logic [7:0] p3_out,
	input  wire logic [7:0] p3_own,
	input  wire logic [7:0] p4_out,
	input  wire logic [7:0] p5_out,
	input  wire logic [7:0] p6_out,
	// data driven back
	output logic      [7:0] p6_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0]  mem [0:65535];
	logic [7:0]  lo_q;
	logic [7:0]  last_q;
	logic [15:0] addr;
	// address from the external latch or from separate pins
	assign addr  = sep ? {p4_out, p5_out} : {p5_out, lo_q};
	assign p6_in = (p3_own[6] && !p3_out[6]) ? mem[addr] : ~last_q;
	// latch low address, capture writes; no pin is driven outside a read
	always @(posedge clk) begin
		if (!sep && p3_own[5] && p3_out[5]) lo_q <= p6_out;
		if (p3_own[7] && !p3_out[7]) mem[addr] <= p6_out;
		last_q <= p6_in;
	end
endmodule

//--- test/tb.sv
// Purpose: random moves over all modes, bus styles and latch widths
// Assumes: one move at a time, next one after the done pulse
// Notes:   on-chip RAM model answers the cycle after its enable
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, arst_n, sfr_wr, mx_req, mx_wide, mx_write, mx_done, ram_en, ram_we;
	logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, mx_index, mx_wdata, mx_rdata, ram_wdata;
	logic [7:0]  ram_rdata, p3_latch, p4_latch, p5_latch, p6_latch, p6_in;
	logic [7:0]  p3_out, p3_oe_n, p3_own, p4_out, p4_oe_n, p4_own;
	logic [7:0]  p5_out, p5_oe_n, p5_own, p6_out, p6_oe_n, p6_own;
	logic [12:0] ram_addr;
	logic [7:0]  ram [0:8191];
	logic [7:0]  page, idx, data_pointer_high, data_pointer_low, cfg, d, exp_lo;
	logic [15:0] ea, n;
	logic [16:0] rt;
	logic [31:0] seed;
	logic        sep, wide;
	int          bad_count, compares, cyc;

	emi_ctrl emi_ctrl_i (.clk(clk), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .mx_req(mx_req), .mx_wide(mx_wide),
		.mx_write(mx_write), .mx_index(mx_index), .mx_wdata(mx_wdata), .mx_done(mx_done),
		.mx_rdata(mx_rdata), .ram_en(ram_en), .ram_we(ram_we), .ram_addr(ram_addr),
		.ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .p3_latch(p3_latch),
		.p4_latch(p4_latch), .p5_latch(p5_latch), .p6_latch(p6_latch), .p6_in(p6_in),
		.p3_out(p3_out), .p3_oe_n(p3_oe_n), .p3_own(p3_own), .p4_out(p4_out),
		.p4_oe_n(p4_oe_n), .p4_own(p4_own), .p5_out(p5_out), .p5_oe_n(p5_oe_n),
		.p5_own(p5_own), .p6_out(p6_out), .p6_oe_n(p6_oe_n), .p6_own(p6_own));
	emi_sram_model emi_sram_model_i (.clk(clk), .sep(sep), .p3_out(p3_out), .p3_own(p3_own),
		.p4_out(p4_out), .p5_out(p5_out), .p6_out(p6_out), .p6_in(p6_in));

	////////////////////////////////////////////////////////////////////////////////
	// clock, hang limit and on-chip RAM
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			test_done();
		end
		if (ram_en && ram_we) ram[ram_addr] <= ram_wdata;
		ram_rdata <= ram[ram_addr];
	end
	// pin direction and address phase while the block holds port 3
	always @(negedge clk) begin
		if (p3_own[6] && (p3_out[6] ^ p3_out[7])) chk(p6_oe_n, {8{p3_out[7]}});
		if (p3_own[5] && p3_out[5]) chk({sep, p6_out}, {1'b0, exp_lo});
	end

	////////////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// expected routing: on-chip flag and off-chip address
	function automatic logic [16:0] route(input logic [1:0] m, input logic w, input logic s,
			input logic [15:0] a, input logic [7:0] h4, input logic [7:0] h5);
		logic on;
		on = (m == emi_pkg::MODE_INTERNAL) || (m != emi_pkg::MODE_EXTERNAL && a < 16'h2000);
		return {on, (w || m == emi_pkg::MODE_SPLIT_BS) ? a[15:8] : (s ? h4 : h5), a[7:0]};
	endfunction
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		{sfr_addr, sfr_wdata, sfr_wr} <= {a, v, 1'b1};
		@(posedge clk);
		sfr_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		sfr_addr <= a;
		@(posedge clk);
		@(negedge clk);
		chk(sfr_rdata, e);
		@(posedge clk);
	endtask
	// one move; counts cycles to done and notes any on-chip access
	task automatic mv(input logic wt, input logic [7:0] dv, input logic on);
		logic [15:0] k;
		logic        h;
		k = 16'h0;
		h = 1'b0;
		{mx_req, mx_wide, mx_write, mx_index, mx_wdata} <= {1'b1, wide, wt, idx, dv};
		@(posedge clk);
		mx_req <= 1'b0;
		do begin
			@(negedge clk);
			k++;
			h |= ram_en;
		end while (mx_done !== 1'b1 && k < 16'd40);
		chk({h, k}, {on, n});
		chk({p3_out, p6_out, p3_own | p4_own | p5_own | p6_own}, {p3_latch, p6_latch, 8'h00});
		@(posedge clk);
	endtask
	task automatic test_done();
		if (bad_count == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence: reset values, then random moves with boundary addresses
	initial begin
		{sfr_addr, sfr_wdata, sfr_wr, mx_req, mx_wide, mx_write, mx_index, mx_wdata} = '0;
		{p3_latch, p4_latch, p5_latch, p6_latch} = '1;
		{arst_n, sep, wide, exp_lo, seed} = {3'h0, 8'h00, 32'h0000_de1d};
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		rd(emi_pkg::PAGE_OFS, emi_pkg::PAGE_RST);
		rd(emi_pkg::CFG_OFS, {3'h0, emi_pkg::CFG_RST});
		rd(emi_pkg::DPH_OFS, emi_pkg::DP_RST);
		rd(8'h55, 8'h00);
		// interface pins never shared with the display driver in this bench
		for (int i = 0; i < 64; i++) begin
			seed = lfsr(seed);
			{data_pointer_high, idx, page, cfg} = seed;
			data_pointer_low = idx ^ 8'h5a;
			// every eighth pass sits on the 8 kB edge
			if (i[2:0] == 3'h0) begin
				page = 8'h1f + 8'(i[3]);
				data_pointer_high = page;
				idx = {8{~i[3]}};
				data_pointer_low = idx;
			end
			{sep, wide, d} = {cfg[4], seed[13], cfg ^ data_pointer_high};
			p4_latch <= data_pointer_high ^ 8'h3c;
			p5_latch <= page ^ 8'ha5;
			wr(emi_pkg::CFG_OFS, cfg);
			wr(emi_pkg::PAGE_OFS, page);
			wr(emi_pkg::DPH_OFS, data_pointer_high);
			wr(emi_pkg::DPL_OFS, data_pointer_low);
			rd(emi_pkg::CFG_OFS, {3'h0, cfg[4:0]});
			rd(emi_pkg::PAGE_OFS, page);
			ea = wide ? {data_pointer_high, data_pointer_low} : {page, idx};
			rt = route(cfg[3:2], wide, sep, ea, data_pointer_high ^ 8'h3c, page ^ 8'ha5);
			exp_lo = ea[7:0];
			n = rt[16] ? 16'h3 : sep ? 16'h5 : 16'(2 * (cfg[1:0] + 1) + 4);
			mv(1'b1, d, rt[16]);
			chk(rt[16] ? ram[ea[12:0]] : emi_sram_model_i.mem[rt[15:0]], d);
			mv(1'b0, ~d, rt[16]);
			chk(mx_rdata, d);
		end
		test_done();
	end
endmodule
